/* rtl/frs_clk_div.sv */
/*
  divider giving a one-cycle tick per algorithm clock cycle.
  assumes ratio_i stays constant outside reset; ratio 1 ticks every cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module frs_clk_div (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] ratio_i,
  output logic tick_o
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // tick lands on the same core edge as each algorithm rising edge
  always_comb begin
    tick_d = (cnt_q == ratio_i - 3'h1);
    cnt_d = tick_d ? 3'h0 : cnt_q + 3'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule : frs_clk_div
`default_nettype wire

/* rtl/frs_pkg.sv */
/*
  shared constants and types of the reset sequencer: register map, field
  positions, reset values, clock-rate options, algorithm reset states.
  assumes a 32-bit classic Wishbone register bus and one system clock.
*/
package frs_pkg;

  // core and algorithm clock rates in MHz
  localparam int unsigned CORE_CLK_MHZ = 200;
  localparam int unsigned ALG_MHZ_200 = 200;
  localparam int unsigned ALG_MHZ_100 = 100;
  localparam int unsigned ALG_MHZ_66 = 66;
  localparam int unsigned ALG_MHZ_50 = 50;

  // one-hot rate selection, exactly one bit may be set
  localparam logic [3:0] ALG_SEL_200 = 4'h1;
  localparam logic [3:0] ALG_SEL_100 = 4'h2;
  localparam logic [3:0] ALG_SEL_66 = 4'h4;
  localparam logic [3:0] ALG_SEL_50 = 4'h8;
  localparam logic [3:0] ALG_SEL_DEF = ALG_SEL_200;

  // algorithm reset pulse length in algorithm clock cycles
  localparam int unsigned ALG_RST_CYCLES = 4;

  // memory banks and default port enables (bank0 read, bank1 write)
  localparam int unsigned NUM_BANKS = 2;
  localparam logic [NUM_BANKS-1:0] RD_EN_DEF = 2'h1;
  localparam logic [NUM_BANKS-1:0] WR_EN_DEF = 2'h2;
  localparam int unsigned NUM_CLKMGR = 2;

  // register map, byte addresses
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h8;

  // field positions
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned ST_CORE_RST_BIT = 0;
  localparam int unsigned ST_ALG_RST_BIT = 1;
  localparam int unsigned ST_CLK_EN_BIT = 2;
  localparam int unsigned ST_STARTED_BIT = 3;
  localparam int unsigned ST_LOCKED_BIT = 4;
  localparam int unsigned ST_CFG_ERR_BIT = 5;
  localparam int unsigned ST_STATE_LSB = 8;
  localparam int unsigned CFG_RATE_LSB = 0;
  localparam int unsigned CFG_RD_EN_LSB = 8;
  localparam int unsigned CFG_WR_EN_LSB = 16;

  // reset values
  localparam logic [1:0] CORE_RST_PIPE_RST = 2'h3;
  localparam logic [2:0] PULSE_CNT_RST = 3'h0;
  localparam logic [31:0] WB_DAT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    FRS_HOLD = 2'b00,
    FRS_PULSE = 2'b01,
    FRS_RUN = 2'b10,
    FRS_IDLE = 2'b11
  } frs_alg_state_e;

  // read and write requests of the algorithm, one bit per bank
  typedef struct packed {
    logic [NUM_BANKS-1:0] rd;
    logic [NUM_BANKS-1:0] wr;
  } frs_mem_req_s;

  // core cycles per algorithm cycle; an invalid selection falls back to 1
  function automatic logic [2:0] frs_ratio(input logic [3:0] sel);
    logic [2:0] r;
    r = 3'h1;
    case (sel)
      ALG_SEL_100: r = 3'(CORE_CLK_MHZ / ALG_MHZ_100);
      ALG_SEL_66: r = 3'(CORE_CLK_MHZ / ALG_MHZ_66);
      ALG_SEL_50: r = 3'(CORE_CLK_MHZ / ALG_MHZ_50);
      default: r = 3'(CORE_CLK_MHZ / ALG_MHZ_200);
    endcase
    return r;
  endfunction : frs_ratio

endpackage : frs_pkg

/* rtl/frs_sync2.sv */
/*
  two-flop level synchroniser, any width, with a defined reset value.
  assumes inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module frs_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : frs_sync2
`default_nettype wire

/* rtl/frs_top.sv */
/*
  reset sequencer: clock manager reset, full-chip and core reset, and the
  algorithm reset with its start pulse, clock gate and memory port gating.
  assumes a classic Wishbone master, lock pins and the chip reset pin
  asynchronous to clk_sys_i, and algorithm logic on clk_sys_i qualified
  by alg_tick_o.
*/
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module frs_top
  import frs_pkg::*;
#(
  parameter logic [3:0] ALG_RATE_SEL = ALG_SEL_DEF,
  parameter logic [NUM_BANKS-1:0] RD_PORT_EN = RD_EN_DEF,
  parameter logic [NUM_BANKS-1:0] WR_PORT_EN = WR_EN_DEF
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic chip_reset_input_i,
  input wire logic [NUM_CLKMGR-1:0] clock_manager_locked_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic alg_done_i,
  input wire frs_mem_req_s alg_mem_req_i,
  output frs_mem_req_s mem_req_o,
  output logic clock_manager_rst_o,
  output logic core_rst_o,
  output logic alg_rst_o,
  output logic alg_clk_en_o,
  output logic alg_tick_o
);

  // build-time configuration checks
  localparam logic CFG_ERR = !(ALG_RATE_SEL inside {ALG_SEL_200, ALG_SEL_100,
                                                    ALG_SEL_66, ALG_SEL_50});
  localparam logic [2:0] ALG_RATIO = frs_ratio(ALG_RATE_SEL);
  localparam logic [2:0] PULSE_LAST = 3'(ALG_RST_CYCLES - 1);
  localparam int PULSE_LAST_I = ALG_RST_CYCLES - 1;

  // clock manager reset: async set straight from the pin, no sync allowed
  // here since the clock managers may have no running clock to sample it
  logic clkmgr_rst_q;
  always_ff @(posedge clk_sys_i or posedge chip_reset_input_i) begin
    if (chip_reset_input_i) begin
      clkmgr_rst_q <= 1'b1;
    end else begin
      clkmgr_rst_q <= 1'b0;
    end
  end
  assign clock_manager_rst_o = clkmgr_rst_q;

  // pins into the clock domain: reset pin and lock indications
  logic [NUM_CLKMGR:0] pins_sync;
  logic chip_rst_sync;
  logic [NUM_CLKMGR-1:0] locked_sync;
  frs_sync2 #(
    .W(NUM_CLKMGR + 1),
    .RST_VAL({1'b1, {NUM_CLKMGR{1'b0}}})
  ) u_pin_sync (
    .clk_i(clk_sys_i),
    .rst_i(sys_rst_i),
    .d_i({chip_reset_input_i, clock_manager_locked_i}),
    .q_o(pins_sync)
  );
  assign chip_rst_sync = pins_sync[NUM_CLKMGR];
  assign locked_sync = pins_sync[NUM_CLKMGR-1:0];

  // full-chip reset and its two-stage release into the core domain
  logic full_rst_q;
  logic full_rst_d;
  logic [1:0] core_pipe_q;
  logic [1:0] core_pipe_d;
  always_comb begin
    full_rst_d = chip_rst_sync | ~(&locked_sync);
    core_pipe_d = full_rst_q ? CORE_RST_PIPE_RST : {core_pipe_q[0], 1'b0};
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      full_rst_q <= 1'b1;
      core_pipe_q <= CORE_RST_PIPE_RST;
    end else begin
      full_rst_q <= full_rst_d;
      core_pipe_q <= core_pipe_d;
    end
  end
  assign core_rst_o = core_pipe_q[1];

  // algorithm clock tick, edge aligned with the core clock
  logic alg_tick;
  frs_clk_div u_alg_div (
    .clk_i(clk_sys_i),
    .rst_i(core_rst_o),
    .ratio_i(ALG_RATIO),
    .tick_o(alg_tick)
  );
  assign alg_tick_o = alg_tick;

  // wishbone slave: one wait state, unmapped reads zero, writes dropped
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic go_wr;
  logic [31:0] status_w;
  logic [31:0] config_w;
  frs_alg_state_e state_q;
  frs_alg_state_e state_d;
  logic started_q;
  logic started_d;
  logic alg_rst_q;
  logic alg_rst_d;
  logic clk_en_q;
  logic clk_en_d;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_CORE_RST_BIT] = core_rst_o;
    status_w[ST_ALG_RST_BIT] = alg_rst_q;
    status_w[ST_CLK_EN_BIT] = clk_en_q;
    status_w[ST_STARTED_BIT] = started_q;
    status_w[ST_LOCKED_BIT] = &locked_sync;
    status_w[ST_CFG_ERR_BIT] = CFG_ERR;
    status_w[ST_STATE_LSB +: 2] = state_q;
    config_w = 32'h0000_0000;
    config_w[CFG_RATE_LSB +: 4] = ALG_RATE_SEL;
    config_w[CFG_RD_EN_LSB +: NUM_BANKS] = RD_PORT_EN;
    config_w[CFG_WR_EN_LSB +: NUM_BANKS] = WR_PORT_EN;
  end

  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d = WB_DAT_RST;
    if (ack_d && !wb_we_i) begin
      case (wb_adr_i)
        REG_STATUS: rdat_d = status_w;
        REG_CONFIG: rdat_d = config_w;
        default: rdat_d = WB_DAT_RST; // control reads zero, go self clears
      endcase
    end
    go_wr = ack_d & wb_we_i & (wb_adr_i == REG_CTRL) & wb_sel_i[0]
            & wb_dat_i[CTRL_GO_BIT];
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= WB_DAT_RST;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // pending go: a write landing on the take cycle is kept for later
  logic go_pend_q;
  logic go_pend_d;
  logic go_take;
  always_comb begin
    go_take = alg_tick & go_pend_q & (state_q != FRS_PULSE);
    go_pend_d = go_wr | (go_pend_q & ~go_take);
  end

  // algorithm reset sequencer; moves only on algorithm clock edges
  logic [2:0] pulse_cnt_q;
  logic [2:0] pulse_cnt_d;
  always_comb begin
    state_d = state_q;
    pulse_cnt_d = pulse_cnt_q;
    started_d = started_q | go_take;
    if (alg_tick) begin
      case (state_q)
        FRS_HOLD, FRS_IDLE: begin
          if (go_pend_q) begin
            state_d = FRS_PULSE;
            pulse_cnt_d = PULSE_CNT_RST;
          end
        end
        FRS_PULSE: begin
          pulse_cnt_d = pulse_cnt_q + 3'h1;
          if (pulse_cnt_q == PULSE_LAST) begin
            state_d = FRS_RUN;
          end
        end
        FRS_RUN: begin
          if (go_pend_q) begin
            state_d = FRS_PULSE; // restart
            pulse_cnt_d = PULSE_CNT_RST;
          end else if (alg_done_i) begin
            state_d = FRS_IDLE; // reset stays off for debug
          end
        end
        default: state_d = FRS_HOLD;
      endcase
    end
    alg_rst_d = (state_d == FRS_HOLD) | (state_d == FRS_PULSE);
    clk_en_d = (state_d == FRS_PULSE) | (state_d == FRS_RUN);
  end

  // core reset forces the hold state until software starts the algorithm
  always_ff @(posedge clk_sys_i) begin
    if (core_rst_o) begin
      state_q <= FRS_HOLD;
      pulse_cnt_q <= PULSE_CNT_RST;
      started_q <= 1'b0;
      go_pend_q <= 1'b0;
      alg_rst_q <= 1'b1;
      clk_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pulse_cnt_q <= pulse_cnt_d;
      started_q <= started_d;
      go_pend_q <= go_pend_d;
      alg_rst_q <= alg_rst_d;
      clk_en_q <= clk_en_d;
    end
  end
  assign alg_rst_o = alg_rst_q;
  assign alg_clk_en_o = clk_en_q;

  // memory port gating: disabled ports never reach the banks; sharing with
  // the DMA engines stays the algorithm's job
  frs_mem_req_s mem_q;
  frs_mem_req_s mem_d;
  always_comb begin
    mem_d.rd = alg_mem_req_i.rd & RD_PORT_EN & {NUM_BANKS{~alg_rst_q}};
    mem_d.wr = alg_mem_req_i.wr & WR_PORT_EN & {NUM_BANKS{~alg_rst_q}};
  end
  always_ff @(posedge clk_sys_i) begin
    if (core_rst_o) begin
      mem_q <= '0;
    end else begin
      mem_q <= mem_d;
    end
  end
  assign mem_req_o = mem_q;

  // helper: algorithm ticks counted while the reset pulse runs
  logic [2:0] hlp_ticks_q;
  always_ff @(posedge clk_sys_i) begin
    if (core_rst_o || state_q != FRS_PULSE) begin
      hlp_ticks_q <= 3'h0;
    end else if (alg_tick) begin
      hlp_ticks_q <= hlp_ticks_q + 3'h1;
    end
  end

  chk_clkmgr_rst_pin: assert property (
    @(posedge clk_sys_i) chip_reset_input_i |-> clock_manager_rst_o)
    else $error("clock manager reset not set by chip reset");

  chk_full_rst_cause: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (chip_rst_sync || !(&locked_sync)) |=> ##1 core_rst_o)
    else $error("core reset missing after chip reset or lock loss");

  chk_core_rst_hold: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(full_rst_q) |-> core_rst_o [*2] ##1 !core_rst_o)
    else $error("core reset release not two cycles after full reset");

  chk_alg_rst_after: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(core_rst_o) |-> alg_rst_o && state_q == FRS_HOLD)
    else $error("algorithm reset released with core reset");

  chk_alg_rst_edges: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i || core_rst_o)
    $changed(alg_rst_o) && !$past(core_rst_o) |-> $past(alg_tick))
    else $error("algorithm reset changed off an algorithm edge");

  chk_pulse_length: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i || core_rst_o)
    $fell(alg_rst_o) |-> $past(hlp_ticks_q) == PULSE_LAST_I)
    else $error("algorithm reset pulse not four algorithm cycles");

  chk_go_starts: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i || core_rst_o)
    go_take |=> alg_rst_o && state_q == FRS_PULSE && started_q)
    else $error("go did not start the reset pulse");

  chk_idle_released: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i || core_rst_o)
    state_q == FRS_IDLE |-> !alg_rst_o && !alg_clk_en_o)
    else $error("idle algorithm in reset or clocked");

  chk_clk_gate: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i || core_rst_o)
    alg_clk_en_o |-> state_q inside {FRS_PULSE, FRS_RUN})
    else $error("algorithm clock enabled while inactive");

  chk_port_gate: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ((mem_req_o.rd & ~RD_PORT_EN) == '0) && ((mem_req_o.wr & ~WR_PORT_EN) == '0))
    else $error("disabled memory port used");

  chk_wb_ack: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not one cycle after request");

endmodule : frs_top
`default_nettype wire

/* tb/frs_alg_model.sv */
/*
  behavioural algorithm block: counts algorithm cycles after its reset
  is released, then raises done; requests memory only while running.
  assumes tick_i marks algorithm clock edges on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module frs_alg_model
  import frs_pkg::*;
#(
  parameter int unsigned DONE_TICKS = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic alg_rst_i,
  input wire logic clk_en_i,
  input wire logic tick_i,
  input wire frs_mem_req_s rnd_req_i,
  output logic done_o,
  output frs_mem_req_s mem_req_o
);
  logic [7:0] run_cnt_q;

  // done is a level held until the next algorithm reset
  always_ff @(posedge clk_i) begin
    if (rst_i || alg_rst_i) begin
      run_cnt_q <= 8'h00;
      done_o <= 1'b0;
    end else if (tick_i && clk_en_i && !done_o) begin
      run_cnt_q <= run_cnt_q + 8'h01;
      done_o <= (run_cnt_q == 8'(DONE_TICKS - 1));
    end
  end

  // own arbitration: ports are claimed only while running
  assign mem_req_o = (clk_en_i && !alg_rst_i && !done_o) ? rnd_req_i
                                                         : '0;
endmodule : frs_alg_model
`default_nettype wire

/* tb/tb_top.sv */
/*
  self-checking bench of the reset sequencer with the algorithm model.
  assumes the 50 MHz rate option, so four core cycles per algorithm cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import frs_pkg::*;
  localparam int RATIO = CORE_CLK_MHZ / ALG_MHZ_50;
  localparam logic [1:0] RD_EN = 2'h2;
  localparam logic [1:0] WR_EN = 2'h1;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, chip_pin = 1'b0;
  logic [1:0] locked = 2'h3;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic [3:0] sel = 4'hF;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, done, cm_rst, core_rst_o, alg_rst_o, alg_clk_en_o, tick;
  frs_mem_req_s rnd_req = '0, alg_req, mem_req_o, exp_req = '0;
  int bad_count = 0, check_count = 0, seed, n, gap = 0, cyc_cnt = 0;
  int rst_cyc, rst_ticks;

  always #2 clk_sys_i = ~clk_sys_i;

  frs_top #(.ALG_RATE_SEL(ALG_SEL_50), .RD_PORT_EN(RD_EN),
    .WR_PORT_EN(WR_EN)) uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .chip_reset_input_i(chip_pin), .clock_manager_locked_i(locked),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .alg_done_i(done), .alg_mem_req_i(alg_req),
    .mem_req_o(mem_req_o), .clock_manager_rst_o(cm_rst),
    .core_rst_o(core_rst_o), .alg_rst_o(alg_rst_o),
    .alg_clk_en_o(alg_clk_en_o), .alg_tick_o(tick));

  frs_alg_model #(.DONE_TICKS(6)) partner (.clk_i(clk_sys_i),
    .rst_i(sys_rst_i), .alg_rst_i(alg_rst_o), .clk_en_i(alg_clk_en_o),
    .tick_i(tick), .rnd_req_i(rnd_req), .done_o(done),
    .mem_req_o(alg_req));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask : check

  // status word expected with the clock managers locked and a valid rate
  function automatic logic [31:0] status_word(input logic ars,
                                              input logic en,
                                              input logic st,
                                              input frs_alg_state_e sq);
    logic [31:0] w;
    w = '0;
    w[ST_ALG_RST_BIT] = ars;
    w[ST_CLK_EN_BIT] = en;
    w[ST_STARTED_BIT] = st;
    w[ST_LOCKED_BIT] = 1'b1;
    w[ST_STATE_LSB +: 2] = sq;
    return w;
  endfunction : status_word

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // one classic cycle; held until ack is sampled high at an edge; only
  // the bench timeout ends a wait for an ack that never comes
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // gated requests and tick spacing, judged on pre-edge values
  always @(posedge clk_sys_i) begin
    rnd_req <= 4'($random(seed));
    // outputs are unknown until the core reset has settled them
    if (core_rst_o === 1'b0) begin
      check(mem_req_o, exp_req, "gated requests");
    end
    exp_req = alg_req & {RD_EN, WR_EN} & {4{~alg_rst_o}};
    if (core_rst_o !== 1'b0 || sys_rst_i) gap = 0;
    else if (tick === 1'b1) begin
      if (gap > 0) check(gap, RATIO, "tick spacing");
      gap = 1;
    end else if (gap > 0) gap++;
    if (alg_rst_o === 1'b1 && alg_clk_en_o === 1'b1) begin
      rst_cyc++;
      if (tick === 1'b1) rst_ticks++;
    end
    cyc_cnt++;
    if (cyc_cnt >= 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    seed = 52;
    repeat (4) @(posedge clk_sys_i);
    check(core_rst_o, 1, "core reset held");
    sys_rst_i <= 1'b0;
    n = 0;
    while (core_rst_o !== 1'b0 && n < 12) begin
      @(posedge clk_sys_i);
      n++;
    end
    check(core_rst_o, 0, "core reset release");
    repeat (10 + ($random(seed) & 15)) @(posedge clk_sys_i);
    check(alg_rst_o, 1, "alg reset before start");
    wb(1'b0, REG_STATUS, 32'h0, rdat);
    check(rdat, status_word(1'b1, 1'b0, 1'b0, FRS_HOLD), "held status");
    wb(1'b0, REG_CONFIG, 32'h0, rdat);
    check(rdat, {14'h0, WR_EN, 6'h0, RD_EN, 4'h0, ALG_SEL_50}, "config");
    wb(1'b0, 4'hC, 32'h0, rdat);
    check(rdat, 0, "unmapped read");
    // third round writes go again inside the pulse: it waits, then reruns
    for (int r = 0; r < 3; r++) begin
      for (int p = 0; p < 1 + r / 2; p++) begin
        rst_cyc = 0;
        rst_ticks = 0;
        n = 0;
        if (p == 0) begin
          wb(1'b1, REG_CTRL, 32'h1, rdat);
        end else begin
          while (alg_rst_o !== 1'b1 && n < 2 * RATIO) begin
            @(posedge clk_sys_i);
            n++;
          end
          check(alg_rst_o, 1, "pending go reruns");
        end
        if (r == 2 && p == 0) begin
          while (alg_clk_en_o !== 1'b1) @(posedge clk_sys_i);
          wb(1'b1, REG_CTRL, 32'h1, rdat);
        end
        n = 0;
        while (!(alg_clk_en_o === 1'b1 && alg_rst_o === 1'b0)
               && n < 100) begin
          @(posedge clk_sys_i);
          n++;
        end
        check(rst_ticks, ALG_RST_CYCLES, "pulse ticks");
        check(rst_cyc, ALG_RST_CYCLES * RATIO, "pulse cycles");
      end
      n = 0;
      while (alg_clk_en_o !== 1'b0 && n < 200) begin
        @(posedge clk_sys_i);
        n++;
      end
      check(alg_clk_en_o, 0, "gate off when done");
      check(alg_rst_o, 0, "reset stays off");
      wb(1'b0, REG_STATUS, 32'h0, rdat);
      check(rdat[9:8], 3, "idle state");
      check(rdat, status_word(1'b0, 1'b0, 1'b1, FRS_IDLE), "idle status");
    end
    // go with its byte lane off, then the lane on with the go bit clear
    sel <= 4'hE;
    wb(1'b1, REG_CTRL, 32'h1, rdat);
    sel <= 4'hF;
    wb(1'b1, REG_CTRL, 32'h0, rdat);
    repeat (3 * RATIO) @(posedge clk_sys_i);
    check(alg_rst_o, 0, "no go without lane and bit");
    check(alg_clk_en_o, 0, "gate stays off");
    wb(1'b0, REG_CTRL, 32'h0, rdat);
    check(rdat, 0, "control reads zero");
    chip_pin <= 1'b1;
    @(negedge clk_sys_i);
    check(cm_rst, 1, "clock manager reset");
    n = 0;
    while (core_rst_o !== 1'b1 && n < 8) begin
      @(posedge clk_sys_i);
      n++;
    end
    check(core_rst_o, 1, "core reset on pin");
    @(posedge clk_sys_i);
    check(alg_rst_o, 1, "alg reset on core reset");
    chip_pin <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    check(cm_rst, 0, "clock manager release");
    check(core_rst_o, 0, "core release after pin");
    locked <= 2'h1;
    n = 0;
    while (core_rst_o !== 1'b1 && n < 8) begin
      @(posedge clk_sys_i);
      n++;
    end
    check(core_rst_o, 1, "core reset on lost lock");
    locked <= 2'h3;
    repeat (10) @(posedge clk_sys_i);
    check(core_rst_o, 0, "core release after lock");
    check(alg_rst_o, 1, "alg reset held after lock");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
